//--- core/dbgc_regs.svh
// register offsets, field positions, reset values and counts of the debugger control block
// Operation
// - writing one to halt bit halts fetch
// - writing zero resumes fetching and executing
// - enabled breakpoint opcode sets halt bit
// - read protection blocks clearing; reset only
// - breakpoint disabled: opcode acts as nop
// - enabled breakpoint acts per loop select
// - ack enable sends all-ones character
// - value 81h resets and halts
// - value 41h resets and runs, breakpoints on
// - value 40h in halt releases processor
`ifndef DBGC_REGS_SVH
`define DBGC_REGS_SVH
// ************************************************************
// register map
// ************************************************************
`define DBGC_ADDR_W        4
`define DBGC_OFS_CTL       4'h0
`define DBGC_OFS_IRQ_STAT  4'h1
`define DBGC_OFS_IRQ_EN    4'h2
`define DBGC_OFS_IRQ_CLR   4'h3
`define DBGC_CTL_RESET     8'h00
`define DBGC_CTL_WMASK     8'hF1
// ************************************************************
// field positions of the control register
// ************************************************************
`define DBGC_BIT_HALT      7
`define DBGC_BIT_BREAKPOINT_ENABLE_BIT     6
`define DBGC_BIT_ACKEN     5
`define DBGC_BIT_LOOP      4
`define DBGC_BIT_RST       0
// ************************************************************
// interrupt status bits, link constants
// ************************************************************
`define DBGC_IRQ_BRK       0
`define DBGC_IRQ_HALT      1
`define DBGC_IRQ_RST       2
`define DBGC_IRQ_W         3
`define DBGC_BRK_OPCODE    8'h00
`define DBGC_ACK_CHAR      8'hFF
`define DBGC_BIT_TIME_NS   1000
`define DBGC_CLK_NS        10
`define DBGC_BIT_CYC       (`DBGC_BIT_TIME_NS / `DBGC_CLK_NS)
`define DBGC_RST_CYC       8'h10
`endif

//--- core/dbgc_pkg.sv
// types shared by the debugger control block
package dbgc_pkg;
   typedef struct packed {
      logic       halt;      // halt mode bit
      logic       breakpoint_enable_bit;     // breakpoint enable
      logic       acken;     // halt ack enable
      logic       loopsel;   // breakpoint loop select
   } dbgc_ctl_t;

   typedef struct packed {
      logic       we;
      logic       re;
      logic [3:0] addr;
      logic [7:0] wdata;
   } dbgc_bus_t;

   typedef enum logic [1:0] {DBGC_TX_IDLE, DBGC_TX_START, DBGC_TX_DATA, DBGC_TX_STOP} dbgc_tx_st_t;
endpackage : dbgc_pkg

//--- core/dbgc_ack_tx.sv
// sends the acknowledge character on the open-drain debug pin
`timescale 1ns/1ps
`include "dbgc_regs.svh"
module dbgc_ack_tx
   import dbgc_pkg::*;
(
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic send,
   output logic      busy,
   output logic      pin_oe
);
   typedef struct packed {
      dbgc_tx_st_t st;
      logic [7:0]  cnt;
      logic [2:0]  bitn;
      logic        oe;
   } dbgc_tx_state_t;

   dbgc_tx_state_t s;
   dbgc_tx_state_t next_s;

   // a macro literal cannot be bit-selected, so the character sits in a constant
   localparam logic [7:0] ack_bits = `DBGC_ACK_CHAR;

   // ************************************************************
   // serial engine: start low, eight data bits lsb first, stop high
   // ************************************************************
   // open drain: a one is sent by releasing the pin, so the all-ones
   // character only pulls low for the start bit
   always_comb begin
      next_s = s;
      if (s.st != DBGC_TX_IDLE) begin
         next_s.cnt = s.cnt - 8'h01;
      end
      case (s.st)
         DBGC_TX_IDLE: begin
            next_s.oe = 1'b0;
            if (send) begin
               next_s.st   = DBGC_TX_START;
               next_s.cnt  = 8'(`DBGC_BIT_CYC - 1);
               next_s.oe   = 1'b1;
               next_s.bitn = 3'h0;
            end
         end
         DBGC_TX_START: begin
            if (s.cnt == 8'h00) begin
               next_s.st  = DBGC_TX_DATA;
               next_s.cnt = 8'(`DBGC_BIT_CYC - 1);
               next_s.oe  = ~ack_bits[0];
            end
         end
         DBGC_TX_DATA: begin
            if (s.cnt == 8'h00) begin
               next_s.cnt = 8'(`DBGC_BIT_CYC - 1);
               if (s.bitn == 3'h7) begin
                  next_s.st = DBGC_TX_STOP;
                  next_s.oe = 1'b0;
               end else begin
                  next_s.bitn = s.bitn + 3'h1;
                  next_s.oe   = ~ack_bits[s.bitn + 3'h1];
               end
            end
         end
         DBGC_TX_STOP: begin
            if (s.cnt == 8'h00) begin
               next_s.st = DBGC_TX_IDLE;
            end
         end
         default: begin
            next_s.st = DBGC_TX_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s <= '{st: DBGC_TX_IDLE, cnt: 8'h00, bitn: 3'h0, oe: 1'b0};
      end else begin
         s <= next_s;
      end
   end

   assign busy   = (s.st != DBGC_TX_IDLE);
   assign pin_oe = s.oe;
endmodule : dbgc_ack_tx

//--- core/dbgc_irq.sv
// sticky event status, enable and clear for the single interrupt line
`timescale 1ns/1ps
`include "dbgc_regs.svh"
module dbgc_irq
   import dbgc_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  nrst,
   input  wire logic [`DBGC_IRQ_W-1:0] events,
   input  wire logic                  en_we,
   input  wire logic                  clr_we,
   input  wire logic [`DBGC_IRQ_W-1:0] wdata,
   output logic [`DBGC_IRQ_W-1:0]      status,
   output logic [`DBGC_IRQ_W-1:0]      enable,
   output logic                       irq
);
   typedef struct packed {
      logic [`DBGC_IRQ_W-1:0] stat;
      logic [`DBGC_IRQ_W-1:0] en;
      logic                   irq;
   } dbgc_irq_state_t;

   dbgc_irq_state_t s;
   dbgc_irq_state_t next_s;

   // set wins over clear so an event in the clear cycle is kept
   always_comb begin
      next_s      = s;
      next_s.stat = (s.stat & ~(clr_we ? wdata : '0)) | events;
      if (en_we) begin
         next_s.en = wdata;
      end
      next_s.irq = |(next_s.stat & next_s.en);
   end

   // state register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign status = s.stat;
   assign enable = s.en;
   assign irq    = s.irq;
endmodule : dbgc_irq

//--- core/dbgc_top.sv
// debugger control register: halt, run, breakpoint and reset commands
`timescale 1ns/1ps
`include "dbgc_regs.svh"
module dbgc_top
   import dbgc_pkg::*;
(
   input  wire logic                    clk,
   input  wire logic                    nrst,
   input  wire logic [`DBGC_ADDR_W-1:0] addr,
   input  wire logic [7:0]              wdata,
   input  wire logic                    we,
   input  wire logic                    re,
   output logic [7:0]                   rdata,
   input  wire logic                    host_we,
   input  wire logic [7:0]              host_wdata,
   input  wire logic                    read_protect,
   input  wire logic                    opcode_valid,
   input  wire logic [7:0]              opcode,
   output logic                         fetch_halt,
   output logic                         brk_as_nop,
   output logic                         brk_loop,
   output logic                         core_reset,
   output logic                         dbg_pin_oe,
   output logic                         dbg_pin_o,
   output logic                         irq
);
   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      dbgc_ctl_t  ctl;
      logic [7:0] rdata;
      logic [7:0] rst_cnt;
      logic       rp_q1;
      logic       rp_q2;
      logic       ack_req;
      logic       brk_evt;
      logic       halt_evt;
      logic       rst_evt;
      logic       nop_out;
      logic       rst_out;
   } dbgc_state_t;

   dbgc_state_t s;
   dbgc_state_t next_s;

   logic                   tx_busy;
   logic                   tx_oe;
   logic [`DBGC_IRQ_W-1:0] irq_stat;
   logic [`DBGC_IRQ_W-1:0] irq_en;
   logic                   irq_q;

   // control register as read back; reserved bits 3..1 and reset bit read zero
   function automatic logic [7:0] ctl_image(input dbgc_ctl_t c);
      logic [7:0] v;
      v                  = 8'h00;
      v[`DBGC_BIT_HALT]  = c.halt;
      v[`DBGC_BIT_BREAKPOINT_ENABLE_BIT] = c.breakpoint_enable_bit;
      v[`DBGC_BIT_ACKEN] = c.acken;
      v[`DBGC_BIT_LOOP]  = c.loopsel;
      return v;
   endfunction : ctl_image

   // apply one write of the control value from either side
   function automatic dbgc_ctl_t ctl_write(input dbgc_ctl_t c, input logic [7:0] v,
                                           input logic rp);
      dbgc_ctl_t n;
      logic [7:0] m;
      m         = v & `DBGC_CTL_WMASK;
      n         = c;
      n.breakpoint_enable_bit   = m[`DBGC_BIT_BREAKPOINT_ENABLE_BIT];
      n.acken   = m[`DBGC_BIT_ACKEN];
      n.loopsel = m[`DBGC_BIT_LOOP];
      if (m[`DBGC_BIT_HALT]) begin
         n.halt = 1'b1;
      end else if (!rp) begin
         n.halt = 1'b0;
      end
      return n;
   endfunction : ctl_write

   // ************************************************************
   // next state
   // ************************************************************
   // local register writes and host link writes share one path; the host
   // wins if both land in one cycle, as it is the debugger in charge
   always_comb begin
      logic        ctl_we;
      logic [7:0]  ctl_val;
      logic        brk_hit;
      ctl_we          = host_we || (we && addr == `DBGC_OFS_CTL);
      ctl_val         = host_we ? host_wdata : wdata;
      brk_hit         = opcode_valid && opcode == `DBGC_BRK_OPCODE && s.ctl.breakpoint_enable_bit;
      next_s          = s;
      next_s.brk_evt  = 1'b0;
      next_s.halt_evt = 1'b0;
      next_s.rst_evt  = 1'b0;
      next_s.ack_req  = 1'b0;
      next_s.rp_q1    = read_protect;
      next_s.rp_q2    = s.rp_q1;
      if (ctl_we) begin
         next_s.ctl = ctl_write(s.ctl, ctl_val, s.rp_q2);
         if (ctl_val[`DBGC_BIT_RST]) begin
            next_s.rst_cnt = `DBGC_RST_CYC;
            next_s.rst_evt = 1'b1;
         end
      end
      // enabled breakpoint halts and raises ack when acken is set; disabled one is a nop
      if (brk_hit) begin
         next_s.ctl.halt = 1'b1;
         next_s.brk_evt  = 1'b1;
         next_s.ack_req  = s.ctl.acken;
      end
      next_s.halt_evt = next_s.ctl.halt && !s.ctl.halt;
      // core reset pulse stretches for a fixed count
      if (s.rst_cnt != 8'h00 && !next_s.rst_evt) begin
         next_s.rst_cnt = s.rst_cnt - 8'h01;
      end
      next_s.rst_out = (next_s.rst_cnt != 8'h00);
      next_s.nop_out = !next_s.ctl.breakpoint_enable_bit;
      // read data stands in the cycle after the strobe only
      next_s.rdata = 8'h00;
      if (re) begin
         case (addr)
            `DBGC_OFS_CTL:      next_s.rdata = ctl_image(s.ctl);
            `DBGC_OFS_IRQ_STAT: next_s.rdata = 8'(irq_stat);
            `DBGC_OFS_IRQ_EN:   next_s.rdata = 8'(irq_en);
            default:            next_s.rdata = 8'h00;
         endcase
      end
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s             <= '0;
         s.ctl         <= dbgc_ctl_t'(4'h0);
         s.nop_out     <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // ************************************************************
   // acknowledge character sender
   // ************************************************************
   // a request while a character is still going out is dropped; each
   // breakpoint hit with acken set that finds the sender idle sends one
   dbgc_ack_tx u_tx (
      .clk    (clk),
      .nrst   (nrst),
      .send   (s.ack_req && !tx_busy),
      .busy   (tx_busy),
      .pin_oe (tx_oe)
   );

   // ************************************************************
   // interrupt
   // ************************************************************
   dbgc_irq u_irq (
      .clk    (clk),
      .nrst   (nrst),
      .events ({s.rst_evt, s.halt_evt, s.brk_evt}),
      .en_we  (we && addr == `DBGC_OFS_IRQ_EN),
      .clr_we (we && addr == `DBGC_OFS_IRQ_CLR),
      .wdata  (wdata[`DBGC_IRQ_W-1:0]),
      .status (irq_stat),
      .enable (irq_en),
      .irq    (irq_q)
   );

   // ************************************************************
   // outputs
   // ************************************************************
   // all from flip-flops except dbg_pin_o, tied low; the pin only ever pulls low
   assign rdata      = s.rdata;
   assign fetch_halt = s.ctl.halt;
   assign brk_as_nop = s.nop_out;
   assign brk_loop   = s.ctl.loopsel;
   assign core_reset = s.rst_out;
   assign dbg_pin_oe = tx_oe;
   assign dbg_pin_o  = 1'b0;
   assign irq        = irq_q;
endmodule : dbgc_top

//--- tb/dbgc_top_checker.sv
// concurrent checks on the ports of the debugger control block
`timescale 1ns/1ps
`include "dbgc_regs.svh"
module dbgc_top_checker
   import dbgc_pkg::*;
(
   input wire logic                    clk,
   input wire logic                    nrst,
   input wire logic [`DBGC_ADDR_W-1:0] addr,
   input wire logic [7:0]              wdata,
   input wire logic                    we,
   input wire logic                    re,
   input wire logic [7:0]              rdata,
   input wire logic                    host_we,
   input wire logic                    read_protect,
   input wire logic                    opcode_valid,
   input wire logic [7:0]              opcode,
   input wire logic                    fetch_halt,
   input wire logic                    brk_as_nop,
   input wire logic                    core_reset,
   input wire logic                    dbg_pin_oe
);
   // ****************
   // helpers
   // ****************
   // three quiet samples cover the two-flop sync of read protect
   logic [1:0] rp_h;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rp_h <= 2'b00;
      end else begin
         rp_h <= {rp_h[0], read_protect};
      end
   end
   wire rp_ok  = !read_protect && rp_h == 2'b00;
   wire rp_hi  = read_protect && rp_h == 2'b11;
   wire ctl_wr = we && addr == `DBGC_OFS_CTL && !host_we;
   wire brk_op = opcode_valid && opcode == `DBGC_BRK_OPCODE && !host_we && !ctl_wr;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence s_rst_pulse;
      core_reset [*8] ##1 core_reset [*8] ##1 !core_reset;
   endsequence
   sequence s_ack_start;
      ##99 dbg_pin_oe ##1 !dbg_pin_oe;
   endsequence
   // ****************
   // assertions
   // ****************
   a_halt_enter: assert property (ctl_wr && wdata[7] |=> fetch_halt)
      else $error("halt write did not halt fetch");
   a_halt_leave: assert property (ctl_wr && !wdata[7] && rp_ok && !opcode_valid |=> !fetch_halt)
      else $error("clear write did not resume fetch");
   a_brk_halt: assert property (brk_op && !brk_as_nop |=> fetch_halt)
      else $error("enabled breakpoint did not halt");
   a_protect_hold: assert property (rp_hi && fetch_halt |=> fetch_halt)
      else $error("halt cleared under read protect");
   a_brk_nop: assert property (brk_op && brk_as_nop && !fetch_halt |=> !fetch_halt)
      else $error("disabled breakpoint halted");
   a_ack_cause: assert property ($rose(dbg_pin_oe) |-> $past(opcode_valid && opcode == 8'h00 && !brk_as_nop, 2))
      else $error("ack character without breakpoint");
   a_ack_start: assert property ($rose(dbg_pin_oe) |-> s_ack_start)
      else $error("ack start bit length wrong");
   a_reset_pulse: assert property (ctl_wr && wdata[0] |=> s_rst_pulse)
      else $error("reset pulse not sixteen cycles");
   a_reset_go: assert property (ctl_wr && wdata == 8'h41 && rp_ok && !opcode_valid |=> !fetch_halt && !brk_as_nop)
      else $error("reset and go wrong");
   a_run_cmd: assert property (fetch_halt && ctl_wr && wdata == 8'h40 && rp_ok && !opcode_valid |=> !fetch_halt && !brk_as_nop && !core_reset)
      else $error("run command wrong");
   a_resv_zero: assert property ($past(re && addr == `DBGC_OFS_CTL) |-> rdata[3:0] == 4'h0)
      else $error("reserved bits read nonzero");
endmodule : dbgc_top_checker

bind dbgc_top dbgc_top_checker i_dbgc_top_checker (.clk(clk), .nrst(nrst), .addr(addr),
   .wdata(wdata), .we(we), .re(re), .rdata(rdata), .host_we(host_we),
   .read_protect(read_protect), .opcode_valid(opcode_valid), .opcode(opcode),
   .fetch_halt(fetch_halt), .brk_as_nop(brk_as_nop), .core_reset(core_reset),
   .dbg_pin_oe(dbg_pin_oe));

//--- tb/dbgc_host_model.sv
// debug host model: link writes to the control register, ack character receiver
`timescale 1ns/1ps
`include "dbgc_regs.svh"
module dbgc_host_model (
   input  wire logic       clk,
   input  wire logic       dbg_pin_oe,
   output logic            host_we,
   output logic [7:0]      host_wdata,
   output logic [7:0]      rx_byte,
   output int              rx_count
);
   // pull-up on the open-drain line: released reads high
   wire        line = dbg_pin_oe ? 1'b0 : 1'b1;
   logic [7:0] sh;
   initial begin
      host_we    = 1'b0;
      host_wdata = 8'h00;
      rx_byte    = 8'h00;
      rx_count   = 0;
   end
   // one link write; data inverted after so a stale value never matches
   task automatic send(input logic [7:0] v);
      @(posedge clk);
      host_wdata <= v;
      host_we    <= 1'b1;
      @(posedge clk);
      host_we    <= 1'b0;
      host_wdata <= ~v;
   endtask : send
   // start edge found, then each bit sampled in its middle
   initial begin
      forever begin
         @(posedge clk);
         if (line === 1'b0) begin
            repeat (50) @(posedge clk);
            for (int b = 0; b < 8; b++) begin
               repeat (`DBGC_BIT_CYC) @(posedge clk);
               sh[b] = line;
            end
            repeat (`DBGC_BIT_CYC) @(posedge clk);
            rx_byte  = sh;
            rx_count = rx_count + 1;
         end
      end
   end
endmodule : dbgc_host_model

//--- tb/dbgc_top_tb.sv
// self-checking bench of the debugger control block against a bench model
`timescale 1ns/1ps
`include "dbgc_regs.svh"
module dbgc_top_tb;
   logic       clk, nrst, we, re, read_protect, opcode_valid, host_we;
   logic       fetch_halt, brk_as_nop, brk_loop, core_reset, dbg_pin_oe, dbg_pin_o, irq;
   logic [3:0] addr;
   logic [7:0] wdata, opcode, rdata, host_wdata, rx_byte, rv, m_ctl;
   int         n_errors = 0, check_count = 0, rx_count, k, n0;
   integer     seed = 32'h0000_2f12;
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   dbgc_top i_dbgc_top (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .we(we),
      .re(re), .rdata(rdata), .host_we(host_we), .host_wdata(host_wdata),
      .read_protect(read_protect), .opcode_valid(opcode_valid), .opcode(opcode),
      .fetch_halt(fetch_halt), .brk_as_nop(brk_as_nop), .brk_loop(brk_loop),
      .core_reset(core_reset), .dbg_pin_oe(dbg_pin_oe), .dbg_pin_o(dbg_pin_o), .irq(irq));
   dbgc_host_model i_dbgc_host_model (.clk(clk), .dbg_pin_oe(dbg_pin_oe), .host_we(host_we),
      .host_wdata(host_wdata), .rx_byte(rx_byte), .rx_count(rx_count));
   // ****************
   // tasks
   // ****************
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         n_errors++;
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      we    <= 1'b1;
      @(posedge clk);
      we    <= 1'b0;
   endtask : wr
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      re   <= 1'b1;
      @(posedge clk);
      re   <= 1'b0;
      #1 chk(rdata, e);
   endtask : rd_chk
   // model keeps the halt bit when a protected clear is refused
   task automatic ctl_wr(input logic [7:0] v, input bit host);
      if (host) i_dbgc_host_model.send(v);
      else wr(`DBGC_OFS_CTL, v);
      m_ctl = (v & 8'hF0) | ((read_protect && m_ctl[7]) ? 8'h80 : 8'h00);
   endtask : ctl_wr
   task automatic ctl_chk;
      #1 chk({5'h00, fetch_halt, brk_as_nop, brk_loop}, {5'h00, m_ctl[7], ~m_ctl[6], m_ctl[4]});
      rd_chk(`DBGC_OFS_CTL, m_ctl);
   endtask : ctl_chk
   task automatic irq_chk(input logic e);
      repeat (2) @(posedge clk);
      #1 chk({7'h00, irq}, {7'h00, e});
   endtask : irq_chk
   task automatic rst_count;
      k = 0;
      repeat (40) begin
         #1 if (core_reset === 1'b1) k++;
         @(posedge clk);
      end
      chk(k[7:0], `DBGC_RST_CYC);
   endtask : rst_count
   task automatic breakpoint_opcode(input logic [7:0] op);
      @(posedge clk);
      opcode       <= op;
      opcode_valid <= 1'b1;
      @(posedge clk);
      opcode_valid <= 1'b0;
      opcode       <= ~op;
      if (op == `DBGC_BRK_OPCODE && m_ctl[6]) m_ctl[7] = 1'b1;
   endtask : breakpoint_opcode
   task automatic do_reset;
      @(posedge clk);
      nrst <= 1'b0;
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      m_ctl = 8'h00;
   endtask : do_reset
   task automatic wrap_up;
      $display("checks=%0d errors=%0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : wrap_up
   // ****************
   // scenarios
   // ****************
   initial begin
      {nrst, we, re, read_protect, opcode_valid} = 5'h00;
      {addr, wdata, opcode, m_ctl} = 28'h000_0000;
      do_reset;
      #1 chk({irq, core_reset, dbg_pin_oe, dbg_pin_o, 4'h0}, 8'h00);
      ctl_chk;
      // random values, reserved bits included, reset bit kept clear
      repeat (8) begin
         rv = 8'($random(seed));
         ctl_wr(rv & 8'hFE, 1'b0);
         ctl_chk;
         rv = 8'($random(seed));
         breakpoint_opcode(rv | 8'h01);
         ctl_chk;
      end
      ctl_wr(8'h00, 1'b0);
      wr(`DBGC_OFS_IRQ_CLR, 8'h07);
      wr(`DBGC_OFS_IRQ_EN, 8'h07);
      ctl_wr(8'h81, 1'b0);
      rst_count;
      ctl_chk;
      rd_chk(`DBGC_OFS_IRQ_STAT, 8'h06);
      irq_chk(1'b1);
      wr(`DBGC_OFS_IRQ_EN, 8'h00);
      irq_chk(1'b0);
      wr(`DBGC_OFS_IRQ_EN, 8'h07);
      wr(`DBGC_OFS_IRQ_CLR, 8'h07);
      irq_chk(1'b0);
      rd_chk(`DBGC_OFS_IRQ_CLR, 8'h00);
      rd_chk(4'hF, 8'h00);
      ctl_wr(8'h40, 1'b0);
      ctl_chk;
      ctl_wr(8'h80, 1'b0);
      ctl_wr(8'h41, 1'b0);
      rst_count;
      ctl_chk;
      ctl_wr(8'h00, 1'b0);
      breakpoint_opcode(8'h00);
      ctl_chk;
      // breakpoint with acknowledge: halt, status and one all-ones character
      ctl_wr(8'h60, 1'b0);
      wr(`DBGC_OFS_IRQ_CLR, 8'h07);
      n0 = rx_count;
      breakpoint_opcode(8'h00);
      ctl_chk;
      rd_chk(`DBGC_OFS_IRQ_STAT, 8'h03);
      k = 0;
      while (rx_count == n0 && k < 1500) begin
         @(posedge clk);
         k++;
      end
      // a lost character counts once; the run goes on to the closing report
      if (k == 1500) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, rx_count, n0 + 1);
         n_errors++;
      end else begin
         chk(rx_byte, `DBGC_ACK_CHAR);
      end
      // protected halt survives bus and link clears, falls only on reset
      read_protect <= 1'b1;
      repeat (4) @(posedge clk);
      ctl_wr(8'h00, 1'b0);
      ctl_chk;
      ctl_wr(8'h40, 1'b1);
      ctl_chk;
      do_reset;
      ctl_chk;
      read_protect <= 1'b0;
      ctl_wr(8'h80, 1'b1);
      ctl_chk;
      wrap_up;
   end
endmodule : dbgc_top_tb
